// >>> design/bsa_sequencer.sv
// bit-stream adc sequencer: feedback flip-flop, decimation, trigger, result
// Operation
// - comparator high: store one, feedback pin low
// - comparator low: store zero, feedback pin high
// - decimate bit stream into eight-bit result
// - start conversion after break plus sync
// - each result overwrites the single result register
// - result returned in fourth response byte
// - conversion samples exactly 1024 oscillator enables, spanning 1023 to 1024 periods
// - new trigger mid-conversion restarts, drops result
// - select one of eight sources at once
`timescale 1ns/1ps
`default_nettype none
module bsa_sequencer
   import bsa_pkg::*;
#(
   parameter int unsigned OSC_DIV = OSC_DIV_DEFAULT,
   parameter int unsigned CONV_LEN = CONV_PERIODS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // comparator sample and feedback pin
   input wire logic comp_i,
   output logic feedback_drive_pin_o,
   output logic feedback_drive_pin_oe_o,
   // source selection
   input wire logic [SRC_W-1:0] adc_source_sel_i,
   output logic [SRC_COUNT-1:0] adc_source_selector_o,
   // slave frame engine side
   input wire logic sync_done_i,
   input wire logic resp_byte_req_i,
   input wire logic [1:0] resp_byte_idx_i,
   output logic [RESULT_W-1:0] port_response_frame_byte_o,
   // status
   output logic busy_o,
   output logic result_valid_o,
   output logic conv_done_o
);
   localparam int CNT_W = $clog2(CONV_LEN + 1);

   // comparator synchroniser, 3 stages
   logic comp_s1;
   logic comp_s2;
   logic comp_s3;
   logic comp_lvl;
   logic next_comp_lvl;
   // oscillator enable divider
   logic [15:0] div_cnt;
   logic [15:0] next_div_cnt;
   logic osc_en;
   // feedback flip-flop
   logic fb_ff;
   logic next_fb_ff;
   // conversion control
   bsa_state_t state;
   bsa_state_t next_state;
   logic [CNT_W-1:0] per_cnt;
   logic [CNT_W-1:0] next_per_cnt;
   logic [CNT_W-1:0] zero_cnt;
   logic [CNT_W-1:0] next_zero_cnt;
   logic wr_res;
   logic next_valid;
   logic [SRC_COUNT-1:0] next_sel;

   function automatic logic [RESULT_W-1:0] scale_zeros(
      input logic [CNT_W-1:0] zeros
   );
      logic [CNT_W+RESULT_W-1:0] prod;
      prod = '0;
      // zeros/len*255; a full window of zeros saturates to the top code
      prod = ((CNT_W+RESULT_W)'(zeros) * (CNT_W+RESULT_W)'(255))
             / (CNT_W+RESULT_W)'(CONV_LEN);
      return prod[RESULT_W-1:0];
   endfunction

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         comp_s1 <= 1'b0;
         comp_s2 <= 1'b0;
         comp_s3 <= 1'b0;
      end else begin
         comp_s1 <= comp_i;
         comp_s2 <= comp_s1;
         comp_s3 <= comp_s2;
      end
   end

   always_comb begin
      // level changes only once stages two and three agree
      next_comp_lvl = comp_lvl;
      if (comp_s2 == comp_s3) begin
         next_comp_lvl = comp_s3;
      end
      // a 16-bit divider limits OSC_DIV to 65536 clocks per period
      next_div_cnt = div_cnt + 16'h0001;
      osc_en = 1'b0;
      if (div_cnt == 16'(OSC_DIV - 1)) begin
         next_div_cnt = 16'h0000;
         osc_en = 1'b1;
      end
      // flip-flop clocked by the sampling edge
      next_fb_ff = fb_ff;
      if (osc_en) begin
         next_fb_ff = comp_lvl;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         comp_lvl <= 1'b0;
         div_cnt <= 16'h0000;
         fb_ff <= 1'b0;
      end else begin
         comp_lvl <= next_comp_lvl;
         div_cnt <= next_div_cnt;
         fb_ff <= next_fb_ff;
      end
   end

   // inverse of the flip-flop drives the 1-bit dac pin
   assign feedback_drive_pin_o = ~fb_ff;
   assign feedback_drive_pin_oe_o = 1'b1;

   always_comb begin
      next_state = state;
      next_per_cnt = per_cnt;
      next_zero_cnt = zero_cnt;
      wr_res = 1'b0;
      next_valid = result_valid_o;
      case (state)
         BSA_IDLE: begin
            if (sync_done_i) begin
               next_state = BSA_CONV;
               next_per_cnt = '0;
               next_zero_cnt = '0;
            end
         end
         BSA_CONV: begin
            if (sync_done_i) begin
               // restart drops the partial result; the master should
               // not allow this, so no error flag is kept
               next_per_cnt = '0;
               next_zero_cnt = '0;
            end else if (osc_en) begin
               next_per_cnt = per_cnt + CNT_W'(1);
               if (!fb_ff) begin
                  next_zero_cnt = zero_cnt + CNT_W'(1);
               end
               if (per_cnt == CNT_W'(CONV_LEN - 1)) begin
                  next_state = BSA_IDLE;
                  wr_res = 1'b1;
                  next_valid = 1'b1;
               end
            end
         end
         default: begin
            next_state = BSA_IDLE;
         end
      endcase
      next_sel = '0;
      next_sel[adc_source_sel_i] = 1'b1;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= BSA_IDLE;
         per_cnt <= '0;
         zero_cnt <= '0;
         result_valid_o <= 1'b0;
         conv_done_o <= 1'b0;
         adc_source_selector_o <= '0;
      end else begin
         state <= next_state;
         per_cnt <= next_per_cnt;
         zero_cnt <= next_zero_cnt;
         result_valid_o <= next_valid;
         conv_done_o <= wr_res;
         adc_source_selector_o <= next_sel;
      end
   end

   assign busy_o = (state == BSA_CONV);

   logic [RESULT_W-1:0] res_rd;
   logic [CNT_W-1:0] fin_zeros;
   // the last enable's sample is not in zero_cnt yet when the result is
   // written, so it is folded in here
   assign fin_zeros = fb_ff ? zero_cnt : zero_cnt + CNT_W'(1);

   bsa_result_reg #(
      .WIDTH(RESULT_W)
   ) u_result (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .wr_i(wr_res),
      .wdata_i(scale_zeros(fin_zeros)),
      .rd_i(resp_byte_req_i),
      .rdata_o(res_rd)
   );

   // response byte: result sits in the fourth byte field, others zero
   logic byte_is_res;
   logic next_byte_is_res;
   always_comb begin
      next_byte_is_res = byte_is_res;
      if (resp_byte_req_i) begin
         next_byte_is_res = (resp_byte_idx_i == 2'(RESP_BYTE_INDEX));
      end
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         byte_is_res <= 1'b0;
      end else begin
         byte_is_res <= next_byte_is_res;
      end
   end
   assign port_response_frame_byte_o = byte_is_res ? res_rd : RESULT_RESET;
endmodule
`default_nettype wire

// >>> design/bsa_pkg.sv
// shared constants for the bit-stream adc sequencer
package bsa_pkg;
   // internal oscillator as a divided enable from clk_i
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned OSC_HZ_DEFAULT = 1_000_000;
   localparam int unsigned OSC_DIV_DEFAULT = CLK_HZ / OSC_HZ_DEFAULT;
   // conversion window in oscillator periods
   localparam int unsigned CONV_PERIODS = 1024;
   localparam int unsigned RESULT_W = 8;
   localparam int unsigned SRC_COUNT = 8;
   localparam int unsigned SRC_W = 3;
   localparam int unsigned RESP_BYTE_INDEX = 3;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [2:0] SRC_RESET = 3'h0;

   typedef enum logic [0:0] {
      BSA_IDLE,
      BSA_CONV
   } bsa_state_t;
endpackage

// >>> design/bsa_result_reg.sv
// result store: overwritten by each finished conversion, registered read
`timescale 1ns/1ps
`default_nettype none
module bsa_result_reg
   import bsa_pkg::*;
#(
   parameter int unsigned WIDTH = RESULT_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // write side
   input wire logic wr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   // read side
   input wire logic rd_i,
   output logic [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] store;
   logic [WIDTH-1:0] next_store;
   logic [WIDTH-1:0] next_rdata;

   always_comb begin
      next_store = store;
      next_rdata = rdata_o;
      if (wr_i) begin
         next_store = wdata_i;
      end
      if (rd_i) begin
         next_rdata = store;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         store <= '0;
         rdata_o <= '0;
      end else begin
         store <= next_store;
         rdata_o <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// >>> test/bsa_seq_props.sv
// port checker for the bit-stream adc sequencer
`timescale 1ns/1ps
`default_nettype none
module bsa_seq_props
   import bsa_pkg::*;
#(
   parameter int unsigned OSC_DIV = OSC_DIV_DEFAULT,
   parameter int unsigned CONV_LEN = CONV_PERIODS
) (
   // watched ports
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic comp_i,
   input wire logic feedback_drive_pin_o,
   input wire logic feedback_drive_pin_oe_o,
   input wire logic [SRC_W-1:0] adc_source_sel_i,
   input wire logic [SRC_COUNT-1:0] adc_source_selector_o,
   input wire logic sync_done_i,
   input wire logic resp_byte_req_i,
   input wire logic [1:0] resp_byte_idx_i,
   input wire logic [RESULT_W-1:0] port_response_frame_byte_o,
   input wire logic busy_o,
   input wire logic result_valid_o,
   input wire logic conv_done_o
);
   // oscillator phase at the trigger leaves one period of slack
   localparam int unsigned LO = (CONV_LEN - 1) * OSC_DIV;
   localparam int unsigned HI = CONV_LEN * OSC_DIV;
   // a steady level reaches the flip-flop after three sync stages, the
   // level filter and at most one oscillator period
   localparam int unsigned SETTLE = OSC_DIV + 4;
   int unsigned run;
   int unsigned next_run;
   int unsigned hi_len;
   int unsigned next_hi_len;
   int unsigned lo_len;
   int unsigned next_lo_len;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence cmp_hi_s;
      hi_len == SETTLE;
   endsequence
   sequence cmp_lo_s;
      lo_len == SETTLE;
   endsequence
   always_comb begin
      next_run = sync_done_i ? 0 : (busy_o ? run + 1 : run);
      // run lengths saturate so a long steady level cannot wrap
      next_hi_len = comp_i ? ((hi_len < SETTLE) ? hi_len + 1 : hi_len) : 0;
      next_lo_len = !comp_i ? ((lo_len < SETTLE) ? lo_len + 1 : lo_len) : 0;
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         run <= 0;
         hi_len <= 0;
         lo_len <= 0;
      end else begin
         run <= next_run;
         hi_len <= next_hi_len;
         lo_len <= next_lo_len;
      end
   end
   fb_high_a: assert property (cmp_hi_s |-> !feedback_drive_pin_o)
      else $error("feedback pin not low");
   fb_low_a: assert property (cmp_lo_s |-> feedback_drive_pin_o)
      else $error("feedback pin not high");
   drive_on_a: assert property (feedback_drive_pin_oe_o)
      else $error("feedback pin not driven");
   start_busy_a: assert property (sync_done_i |=> busy_o)
      else $error("trigger did not start");
   conv_len_a: assert property (conv_done_o |->
      !busy_o && run >= LO && run <= HI) else $error("bad length");
   valid_keep_a: assert property ((conv_done_o || result_valid_o)
      |=> result_valid_o) else $error("valid flag lost");
   valid_set_a: assert property (conv_done_o |-> result_valid_o)
      else $error("valid flag not set with result");
   sel_hot_a: assert property ($past(nrst_i) |->
      adc_source_selector_o == (SRC_COUNT'(1) << $past(adc_source_sel_i)))
      else $error("selector not one-hot of index");
   resp_zero_a: assert property (resp_byte_req_i &&
      resp_byte_idx_i != 2'h3 |=> port_response_frame_byte_o == 8'h00)
      else $error("non-result byte not zero");
   resp_hold_a: assert property (!resp_byte_req_i
      |=> $stable(port_response_frame_byte_o)) else $error("byte moved");
endmodule
`default_nettype wire

// >>> test/bsa_rc_model.sv
// external integrator and comparator in front of the sequencer
`timescale 1ns/1ps
`default_nettype none
module bsa_rc_model (
   // clock and mode
   input wire logic clk_i,
   input wire logic [1:0] mode_i,
   // pin side
   input wire logic fb_pin_i,
   output logic comp_o
);
   int acc = 0;
   // modes 0 and 1 pin the comparator, mode 2 closes the loop
   always @(posedge clk_i) begin
      acc <= (mode_i != 2'h2) ? 0 : (fb_pin_i ? acc + 1 : acc - 1);
   end
   assign comp_o = (mode_i == 2'h2) ? (acc > 0) : mode_i[0];
endmodule
`default_nettype wire

// >>> test/bitstream_adc_sequencer_tb.sv
// self-checking bench for the bit-stream adc sequencer
`timescale 1ns/1ps
`default_nettype none
module bitstream_adc_sequencer_tb;
   import bsa_pkg::*;
   typedef struct packed {logic [1:0] md; logic [2:0] sel;
      logic [7:0] res;} bsa_row_t;
   localparam bsa_row_t ROWS [4] = '{'{2'h1, 3'h0, 8'h00},
      '{2'h0, 3'h7, 8'hff}, '{2'h1, 3'h3, 8'h00}, '{2'h0, 3'h5, 8'hff}};
   logic clk_i = 0, nrst_i = 0, comp, fb, oe, sync = 0, req = 0;
   logic busy, vld, done;
   logic [1:0] idx = 0, md = 1;
   logic [2:0] sel = 0;
   logic [7:0] sel_o, rb;
   int num_errors = 0, cmp_count = 0, n;
   bsa_sequencer #(.OSC_DIV(2), .CONV_LEN(16)) dut_u (.clk_i(clk_i),
      .nrst_i(nrst_i), .comp_i(comp), .feedback_drive_pin_o(fb),
      .feedback_drive_pin_oe_o(oe), .adc_source_sel_i(sel),
      .adc_source_selector_o(sel_o), .sync_done_i(sync),
      .resp_byte_req_i(req), .resp_byte_idx_i(idx),
      .port_response_frame_byte_o(rb), .busy_o(busy),
      .result_valid_o(vld), .conv_done_o(done));
   bsa_rc_model m_u (.clk_i(clk_i), .mode_i(md), .fb_pin_i(fb),
      .comp_o(comp));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   task automatic complete_run();
      if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pulse();
      @(posedge clk_i) sync <= 1'b1;
      @(posedge clk_i) sync <= 1'b0;
   endtask
   // bounded wait so a lost trigger shows as a mismatch, not a hang
   task automatic conv();
      pulse();
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (done !== 1'b1 && n < 100);
      chk({7'h0, done}, 8'h01);
   endtask
   task automatic rd(input logic [1:0] i);
      @(posedge clk_i) begin
         req <= 1'b1;
         idx <= i;
      end
      @(posedge clk_i) req <= 1'b0;
      #1;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      chk({6'h0, fb, vld}, 8'h02);
      nrst_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i) md <= ROWS[i].md;
         sel <= ROWS[i].sel;
         repeat (12) @(posedge clk_i);
         conv();
         chk({7'h0, vld}, 8'h01);
         rd(2'h3);
         chk(rb, ROWS[i].res);
         rd(2'h0);
         chk(rb, 8'h00);
         chk(sel_o, 8'h01 << ROWS[i].sel);
      end
      pulse();
      repeat (10) @(posedge clk_i);
      conv();
      chk(8'(n > 25), 8'h01);
      @(posedge clk_i) md <= 2'h2;
      repeat (40) @(posedge clk_i);
      conv();
      rd(2'h3);
      chk(8'(rb > 8'h20 && rb < 8'he0), 8'h01);
      // reset in mid-conversion clears busy and the valid flag
      pulse();
      repeat (4) @(posedge clk_i);
      #1;
      chk({7'h0, busy}, 8'h01);
      @(posedge clk_i) nrst_i <= 1'b0;
      #1;
      chk({5'h0, fb, vld, busy}, 8'h04);
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      conv();
      chk({7'h0, vld}, 8'h01);
      complete_run();
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      num_errors++;
      complete_run();
   end
endmodule
bind bsa_sequencer bsa_seq_props #(.OSC_DIV(OSC_DIV), .CONV_LEN(CONV_LEN))
   p_u (.clk_i(clk_i), .nrst_i(nrst_i), .comp_i(comp_i),
   .feedback_drive_pin_o(feedback_drive_pin_o),
   .feedback_drive_pin_oe_o(feedback_drive_pin_oe_o),
   .adc_source_sel_i(adc_source_sel_i),
   .adc_source_selector_o(adc_source_selector_o),
   .sync_done_i(sync_done_i), .resp_byte_req_i(resp_byte_req_i),
   .resp_byte_idx_i(resp_byte_idx_i),
   .port_response_frame_byte_o(port_response_frame_byte_o),
   .busy_o(busy_o), .result_valid_o(result_valid_o),
   .conv_done_o(conv_done_o));
`default_nettype wire
